// File: test/timer_channel_value_regs_tb.sv
// Self-checking bench for the channel value registers, driven over APB.
// Assumes tcv_pkg is compiled first; the bench alone drives counter and pins.
`timescale 1ns/1ps
module timer_channel_value_regs_tb;
  logic clock;
  logic rst_b;
  logic psel;
  logic penable;
  logic pwrite;
  logic [9:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] counterValue;
  logic [3:0] capturePin;
  logic [3:0] channelEventFlag;
  logic irq;
  logic [31:0] rdData;
  logic rdErr;
  int n_errors;
  int checked;
  logic [7:0] idxTab [8] = '{tcv_pkg::IDX_CH0_HIGH, tcv_pkg::IDX_CH0_LOW,
    tcv_pkg::IDX_CH1_HIGH, tcv_pkg::IDX_CH1_LOW, tcv_pkg::IDX_CH2_HIGH,
    tcv_pkg::IDX_CH2_LOW, tcv_pkg::IDX_CH3_HIGH, tcv_pkg::IDX_CH3_LOW};

  tcv_channel_values u_dut (
    .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .counterValue(counterValue), .capturePin(capturePin),
    .channelEventFlag(channelEventFlag), .irq(irq)
  );

  // ==========================================================================
  // Clock, closing task and watchdog
  // ==========================================================================
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic finish_test();
    if (n_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Whole run is a few hundred cycles; this leaves ample margin
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end

  // ==========================================================================
  // APB master and compare helpers
  // ==========================================================================
  // Waits one edge first so a release and the next setup never share a step
  task automatic apb(input logic wr, input logic [9:0] addr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_errors++;
      $display("[ERR] %0t no pready", $time);
    end
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, {idx, 2'b00}, d);
  endtask

  task automatic rd(input logic [7:0] idx);
    apb(1'b0, {idx, 2'b00}, 32'h0000_0000);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic pinRise(input int ch);
    @(posedge clock);
    capturePin[ch] <= 1'b0;
    repeat (8) @(posedge clock);
    capturePin[ch] <= 1'b1;
    repeat (10) @(posedge clock);
  endtask

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    n_errors = 0;
    checked = 0;
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h000;
    pwdata = 32'h0000_0000;
    counterValue = 16'h0000;
    capturePin = 4'h0;
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    // Own registers come up cleared; value bytes have no reset value to check
    rd(tcv_pkg::IDX_MODE);
    chk(rdData[15:0], tcv_pkg::MODE_RESET);
    rd(tcv_pkg::IDX_MASK);
    chk(rdData[3:0], tcv_pkg::MASK_RESET);
    // All channels idle: every byte register holds what software wrote
    for (int i = 0; i < 8; i++) begin
      wr(idxTab[i], 32'h0000_00A0 + i);
    end
    for (int i = 0; i < 8; i++) begin
      rd(idxTab[i]);
      chk({24'h00_0000, rdData[7:0]}, 32'h0000_00A0 + i);
      chk({31'h0, rdErr}, 32'h0000_0000);
    end
    // Unmapped index and unaligned byte address are refused
    rd(8'h47);
    chk({31'h0, rdErr}, 32'h0000_0001);
    chk(rdData, tcv_pkg::UNMAPPED_DATA);
    apb(1'b0, {tcv_pkg::IDX_CH0_HIGH, 2'b01}, 32'h0000_0000);
    chk({31'h0, rdErr}, 32'h0000_0001);
    // Ch0 unbuffered compare, ch1 rising-edge capture
    wr(tcv_pkg::IDX_MODE, 32'h0000_0045);
    wr(tcv_pkg::IDX_MASK, 32'h0000_0001);
    wr(tcv_pkg::IDX_CH0_HIGH, 32'h0000_0012);
    counterValue <= 16'h12A1;
    repeat (8) @(posedge clock);
    chk({28'h0, channelEventFlag}, 32'h0000_0000);
    counterValue <= 16'h0000;
    wr(tcv_pkg::IDX_CH0_LOW, 32'h0000_0034);
    counterValue <= 16'h1234;
    repeat (4) @(posedge clock);
    counterValue <= 16'h0000;
    repeat (4) @(posedge clock);
    chk({28'h0, channelEventFlag}, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(tcv_pkg::IDX_STATUS, 32'h0000_0001);
    repeat (3) @(posedge clock);
    chk({28'h0, channelEventFlag}, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    // Masked event sets the flag but keeps the interrupt low
    wr(tcv_pkg::IDX_MASK, 32'h0000_0000);
    counterValue <= 16'h1234;
    repeat (4) @(posedge clock);
    chk({28'h0, channelEventFlag}, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
    // A standing match would win over the clear, so move the counter first
    counterValue <= 16'h0000;
    wr(tcv_pkg::IDX_STATUS, 32'h0000_0001);
    // Capture, then a second edge while the high byte read is pending
    counterValue <= 16'hBEEF;
    pinRise(1);
    chk({28'h0, channelEventFlag}, 32'h0000_0002);
    rd(tcv_pkg::IDX_CH1_HIGH);
    chk({24'h00_0000, rdData[7:0]}, 32'h0000_00BE);
    counterValue <= 16'h5A5A;
    pinRise(1);
    rd(tcv_pkg::IDX_CH1_LOW);
    chk({24'h00_0000, rdData[7:0]}, 32'h0000_00EF);
    rd(tcv_pkg::IDX_CH1_HIGH);
    chk({24'h00_0000, rdData[7:0]}, 32'h0000_00BE);
    rd(tcv_pkg::IDX_CH1_LOW);
    // Inhibit has ended, so the next edge captures again
    pinRise(1);
    rd(tcv_pkg::IDX_CH1_HIGH);
    chk({24'h00_0000, rdData[7:0]}, 32'h0000_005A);
    rd(tcv_pkg::IDX_CH1_LOW);
    chk({24'h00_0000, rdData[7:0]}, 32'h0000_005A);
    // Ch2 falling-edge capture, ch3 buffered compare
    wr(tcv_pkg::IDX_MODE, 32'h0000_6845);
    wr(tcv_pkg::IDX_STATUS, 32'h0000_000F);
    counterValue <= 16'hC3C3;
    pinRise(2);
    chk({28'h0, channelEventFlag}, 32'h0000_0000);
    pinRise(2);
    chk({28'h0, channelEventFlag}, 32'h0000_0004);
    rd(tcv_pkg::IDX_CH2_HIGH);
    chk({24'h00_0000, rdData[7:0]}, 32'h0000_00C3);
    rd(tcv_pkg::IDX_CH2_LOW);
    chk({24'h00_0000, rdData[7:0]}, 32'h0000_00C3);
    counterValue <= 16'hA6A7;
    repeat (3) @(posedge clock);
    chk({28'h0, channelEventFlag}, 32'h0000_000C);
    finish_test();
  end
endmodule

// File: verilog/tcv_channel_values.sv
// Capture/compare value registers for a four-channel 16-bit timer.
// Assumes a running counter on the same clock and asynchronous capture pins.
//
// How it works
// - Capture mode stores counter on active edge; compare mode stores written value.
// - Each channel value is 16 bits split into high and low byte registers.
// - Value registers have no reset; software initialises them before use.
// - Capture mode: reading high byte blocks captures until low byte is read.
// - Compare modes: writing high byte blocks matches until low byte is written.
// - With edge select nonzero, buffered or unbuffered select picks compare; neither picks capture.
// - Compare mode flags the channel when counter equals its 16-bit value.
`timescale 1ns/1ps
module tcv_channel_values #(
  parameter int CHANNELS = 4, // Number of channels
  parameter int COUNT_W = 16 // Counter width
) (
  input wire logic clock, // Bus clock, 200 MHz
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [9:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic [COUNT_W-1:0] counterValue, // Running timer counter
  input wire logic [CHANNELS-1:0] capturePin, // Asynchronous capture inputs
  output logic [CHANNELS-1:0] channelEventFlag, // Sticky event flags
  output logic irq // Level interrupt
);
  // =========================================================================
  // Elaboration checks
  // =========================================================================
  if (CHANNELS != 4) begin : g_bad_channels
    $error("Only four channels are mapped");
  end
  if (COUNT_W != 16) begin : g_bad_width
    $error("Counter must be 16 bits");
  end

  // =========================================================================
  // Helpers
  // =========================================================================
  // Index of a channel's high byte register
  function automatic logic [7:0] highIdx(input int ch);
    case (ch)
      0: highIdx = tcv_pkg::IDX_CH0_HIGH;
      1: highIdx = tcv_pkg::IDX_CH1_HIGH;
      2: highIdx = tcv_pkg::IDX_CH2_HIGH;
      default: highIdx = tcv_pkg::IDX_CH3_HIGH;
    endcase
  endfunction

  function automatic logic [7:0] lowIdx(input int ch);
    case (ch)
      0: lowIdx = tcv_pkg::IDX_CH0_LOW;
      1: lowIdx = tcv_pkg::IDX_CH1_LOW;
      2: lowIdx = tcv_pkg::IDX_CH2_LOW;
      default: lowIdx = tcv_pkg::IDX_CH3_LOW;
    endcase
  endfunction

  // =========================================================================
  // APB handshake: one wait state, answer in the second access cycle
  // =========================================================================
  logic [7:0] regIdx;
  logic accessCyc;
  logic aligned;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic wrStrobe;
  logic rdStrobe;
  logic mapped;

  assign regIdx = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'b00);
  assign accessCyc = psel && penable && !pready_ff;
  // Writes land at the edge where the master sees pready; reads act one edge
  // earlier, with the data latch, so only a capture in that same cycle can split a high-byte read
  assign wrStrobe = psel && penable && pready_ff && pwrite && aligned;
  assign rdStrobe = accessCyc && !pwrite && aligned;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= accessCyc;
    end
  end

  // =========================================================================
  // Channel state
  // =========================================================================
  logic [7:0] valHigh_ff [CHANNELS];
  logic [7:0] valLow_ff [CHANNELS];
  logic [15:0] mode_ff;
  logic [CHANNELS-1:0] inhibit_ff;
  logic [CHANNELS-1:0] status_ff;
  logic [CHANNELS-1:0] mask_ff;
  logic [CHANNELS-1:0] pinLevel;
  logic [CHANNELS-1:0] pinPrev_ff;
  logic [CHANNELS-1:0] captureMode;
  logic [CHANNELS-1:0] compareMode;
  logic [CHANNELS-1:0] captureEvt;
  logic [CHANNELS-1:0] matchEvt;
  logic [CHANNELS-1:0] hiRd;
  logic [CHANNELS-1:0] loRd;
  logic [CHANNELS-1:0] hiWr;
  logic [CHANNELS-1:0] loWr;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      mode_ff <= tcv_pkg::MODE_RESET;
    end else if (wrStrobe && regIdx == tcv_pkg::IDX_MODE) begin
      mode_ff <= pwdata[15:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      mask_ff <= tcv_pkg::MASK_RESET;
    end else if (wrStrobe && regIdx == tcv_pkg::IDX_MASK) begin
      mask_ff <= pwdata[CHANNELS-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pinPrev_ff <= '0;
    end else begin
      pinPrev_ff <= pinLevel;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++) begin : g_ch
      logic [3:0] fld;
      logic elsHi;
      logic elsLo;
      logic rise;
      logic fall;

      tcv_pin_sync u_sync (
        .clock(clock),
        .rst_b(rst_b),
        .pinIn(capturePin[gi]),
        .pinLevel(pinLevel[gi])
      );

      assign fld = mode_ff[gi*tcv_pkg::MODE_FIELD_W +: tcv_pkg::MODE_FIELD_W];
      assign elsHi = fld[tcv_pkg::MODE_ELS_HI_POS];
      assign elsLo = fld[tcv_pkg::MODE_ELS_LO_POS];
      // Buffered select also counts as a compare mode
      assign captureMode[gi] = (elsHi || elsLo) && !fld[tcv_pkg::MODE_BUF_POS]
        && !fld[tcv_pkg::MODE_UNBUF_POS];
      assign compareMode[gi] = (elsHi || elsLo) && (fld[tcv_pkg::MODE_BUF_POS]
        || fld[tcv_pkg::MODE_UNBUF_POS]);
      assign rise = pinLevel[gi] && !pinPrev_ff[gi];
      assign fall = !pinLevel[gi] && pinPrev_ff[gi];
      assign captureEvt[gi] = captureMode[gi] && !inhibit_ff[gi]
        && ((elsLo && rise) || (elsHi && fall));
      assign matchEvt[gi] = compareMode[gi] && !inhibit_ff[gi]
        && (counterValue == {valHigh_ff[gi], valLow_ff[gi]});

      assign hiRd[gi] = rdStrobe && regIdx == highIdx(gi);
      assign loRd[gi] = rdStrobe && regIdx == lowIdx(gi);
      assign hiWr[gi] = wrStrobe && regIdx == highIdx(gi);
      assign loWr[gi] = wrStrobe && regIdx == lowIdx(gi);

      // No reset: contents are undefined until software writes them
      always_ff @(posedge clock) begin
        if (captureEvt[gi]) begin
          valHigh_ff[gi] <= counterValue[15:8];
        end else if (hiWr[gi]) begin
          valHigh_ff[gi] <= pwdata[7:0];
        end
      end

      always_ff @(posedge clock) begin
        if (captureEvt[gi]) begin
          valLow_ff[gi] <= counterValue[7:0];
        end else if (loWr[gi]) begin
          valLow_ff[gi] <= pwdata[7:0];
        end
      end

      // Low-byte access completes the pair and frees the channel next cycle
      always_ff @(posedge clock) begin
        if (!rst_b) begin
          inhibit_ff[gi] <= 1'b0;
        end else if ((captureMode[gi] && loRd[gi]) || (!captureMode[gi] && loWr[gi])) begin
          inhibit_ff[gi] <= 1'b0;
        end else if (captureMode[gi] && hiRd[gi]) begin
          inhibit_ff[gi] <= 1'b1;
        end else if (!captureMode[gi] && hiWr[gi]) begin
          inhibit_ff[gi] <= 1'b1;
        end
      end

      // Set wins over the write-one clear
      always_ff @(posedge clock) begin
        if (!rst_b) begin
          status_ff[gi] <= 1'b0;
        end else if (captureEvt[gi] || matchEvt[gi]) begin
          status_ff[gi] <= 1'b1;
        end else if (wrStrobe && regIdx == tcv_pkg::IDX_STATUS && pwdata[gi]) begin
          status_ff[gi] <= 1'b0;
        end
      end

      // =====================================================================
      // Assertions
      // =====================================================================
      sequence hiAccess_s;
        (captureMode[gi] && hiRd[gi] && !loRd[gi]);
      endsequence

      inhibit_set_a: assert property (@(posedge clock) disable iff (!rst_b)
        hiAccess_s |=> inhibit_ff[gi])
        else $error("High byte read did not block captures");
      write_inhibit_a: assert property (@(posedge clock) disable iff (!rst_b)
        (!captureMode[gi] && hiWr[gi]) |=> inhibit_ff[gi])
        else $error("High byte write did not block matches");
      inhibit_end_a: assert property (@(posedge clock) disable iff (!rst_b)
        (captureMode[gi] && loRd[gi]) |=> !inhibit_ff[gi])
        else $error("Low byte read did not release inhibit");
      no_capture_a: assert property (@(posedge clock) disable iff (!rst_b)
        (inhibit_ff[gi] && !status_ff[gi]) |=> !status_ff[gi])
        else $error("Event recorded while inhibited");
      capture_value_a: assert property (@(posedge clock) disable iff (!rst_b)
        captureEvt[gi] |=> {valHigh_ff[gi], valLow_ff[gi]} == $past(counterValue))
        else $error("Captured value differs from counter");
      match_flag_a: assert property (@(posedge clock) disable iff (!rst_b)
        (compareMode[gi] && !inhibit_ff[gi]
          && counterValue == {valHigh_ff[gi], valLow_ff[gi]}) |=> status_ff[gi])
        else $error("Compare match did not set flag");
      write_high_a: assert property (@(posedge clock) disable iff (!rst_b)
        (hiWr[gi] && !captureEvt[gi]) |=> valHigh_ff[gi] == $past(pwdata[7:0]))
        else $error("High byte write lost");
      mode_select_a: assert property (@(posedge clock) disable iff (!rst_b)
        (fld[3:2] != 2'b00) |-> (captureMode[gi] ^ compareMode[gi]))
        else $error("Mode decode not exclusive");
    end
  endgenerate

  // =========================================================================
  // Read mux and outputs
  // =========================================================================
  logic [31:0] rdMux;

  always_comb begin
    rdMux = tcv_pkg::UNMAPPED_DATA;
    mapped = 1'b0;
    for (int c = 0; c < CHANNELS; c++) begin
      if (regIdx == highIdx(c)) begin
        rdMux = {24'h00_0000, valHigh_ff[c]};
        mapped = 1'b1;
      end
      if (regIdx == lowIdx(c)) begin
        rdMux = {24'h00_0000, valLow_ff[c]};
        mapped = 1'b1;
      end
    end
    if (regIdx == tcv_pkg::IDX_MODE) begin
      rdMux = {16'h0000, mode_ff};
      mapped = 1'b1;
    end
    if (regIdx == tcv_pkg::IDX_STATUS) begin
      rdMux = {28'h000_0000, status_ff};
      mapped = 1'b1;
    end
    if (regIdx == tcv_pkg::IDX_MASK) begin
      rdMux = {28'h000_0000, mask_ff};
      mapped = 1'b1;
    end
    if (!aligned) begin
      mapped = 1'b0;
      rdMux = tcv_pkg::UNMAPPED_DATA;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      prdata_ff <= tcv_pkg::UNMAPPED_DATA;
      pslverr_ff <= 1'b0;
    end else if (accessCyc) begin
      prdata_ff <= pwrite ? tcv_pkg::UNMAPPED_DATA : rdMux;
      pslverr_ff <= !mapped;
    end else begin
      pslverr_ff <= 1'b0;
    end
  end

  logic irq_ff;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(status_ff & mask_ff);
    end
  end

  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign prdata = prdata_ff;
  assign channelEventFlag = status_ff;
  assign irq = irq_ff;
endmodule

// File: verilog/tcv_pin_sync.sv
// Three-flop synchroniser with a two-flop agreement filter for one pin.
// Assumes the pin is asynchronous to clock.
`timescale 1ns/1ps
module tcv_pin_sync (
  input wire logic clock, // Bus clock
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic pinIn, // Asynchronous pin level
  output logic pinLevel // Filtered level
);
  logic [tcv_pkg::SYNC_STAGES-1:0] stage_ff;
  logic level_ff;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      stage_ff <= '0;
    end else begin
      stage_ff <= {stage_ff[tcv_pkg::SYNC_STAGES-2:0], pinIn};
    end
  end

  // Change counts only when the second and third stages agree
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      level_ff <= 1'b0;
    end else if (stage_ff[1] == stage_ff[2]) begin
      level_ff <= stage_ff[2];
    end
  end

  assign pinLevel = level_ff;
endmodule

// File: verilog/tcv_pkg.sv
// Constants for the timer channel value register block.
// Assumes an APB slave with 32-bit data; each register takes one aligned word.
package tcv_pkg;
  // =========================================================================
  // Register indices (printed offsets are not all multiples of four)
  // =========================================================================
  localparam logic [7:0] IDX_CH0_HIGH = 8'h45;
  localparam logic [7:0] IDX_CH0_LOW = 8'h46;
  localparam logic [7:0] IDX_CH1_HIGH = 8'h48;
  localparam logic [7:0] IDX_CH1_LOW = 8'h49;
  localparam logic [7:0] IDX_CH2_HIGH = 8'h4B;
  localparam logic [7:0] IDX_CH2_LOW = 8'h4C;
  localparam logic [7:0] IDX_CH3_HIGH = 8'h4E;
  localparam logic [7:0] IDX_CH3_LOW = 8'h4F;
  // Own registers: per-channel mode, event status and mask
  localparam logic [7:0] IDX_MODE = 8'h60;
  localparam logic [7:0] IDX_STATUS = 8'h61;
  localparam logic [7:0] IDX_MASK = 8'h62;
  // =========================================================================
  // Mode register field layout, four bits per channel
  // =========================================================================
  localparam int MODE_FIELD_W = 4;
  localparam int MODE_UNBUF_POS = 0;
  localparam int MODE_BUF_POS = 1;
  localparam int MODE_ELS_LO_POS = 2;
  localparam int MODE_ELS_HI_POS = 3;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [3:0] STATUS_RESET = 4'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
  // Input synchroniser depth for the capture pins
  localparam int SYNC_STAGES = 3;
endpackage
